// ==== dv/spx_peer.sv ====
// Behavioural slave peer that faces the engine when it runs as master.
`timescale 1ns/1ns
`default_nettype none
module spx_peer (
  // Serial pins.
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  // Format, set alike on both ends.
  input  wire logic        clock_polarity_select,
  input  wire logic        clock_phase_select,
  input  wire logic        lsbf,
  input  wire logic        w16,
  // Words.
  input  wire logic [15:0] word,
  output logic [15:0]      got,
  output int               ndone
);
  int          bi;
  int          ri;
  int          n;
  logic [15:0] sh;

  function automatic logic pick(input int i);
    return lsbf ? word[i] : word[n-1-i];
  endfunction : pick

  initial begin
    miso  = 1'b0;
    got   = 16'h0000;
    ndone = 0;
    n     = 8;
  end

  always @(negedge ss_n) begin
    n  = w16 ? 16 : 8;
    bi = 0;
    ri = 0;
    sh = 16'h0000;
    if (!clock_phase_select) miso = pick(0);
  end

  // A released data line shows the inverse of its last level.
  always @(posedge ss_n) miso = ~miso;

  // Indices restart at each word, so select may stay low between phase 1 words.
  always @(sck) if (!ss_n) begin
    if ((sck !== clock_polarity_select) ^ clock_phase_select) begin
      sh[lsbf ? ri : n-1-ri] = mosi;
      ri = ri + 1;
      if (ri == n) begin
        got   = sh;
        sh    = 16'h0000;
        ri    = 0;
        bi    = 0;
        ndone = ndone + 1;
      end
    end else begin
      if (!clock_phase_select) bi = bi + 1;
      if (bi < n) miso = pick(bi);
      if (clock_phase_select) bi = bi + 1;
    end
  end
endmodule : spx_peer
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the serial shift engine against a slave peer.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import spx_pkg::*;
  logic        clk, arst_n, mst, clock_polarity_select, clock_phase_select, lsbf, w16, soe, fde, flag_clr;
  logic [2:0]  pre, rate;
  logic        tx_valid, tx_ready, rx_stb, flag, busy, chk_on, sck_q, ss_q, lw;
  logic [15:0] tx_data, rx_data, got;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic        b_sck, b_mosi, b_ss, p_miso, sck_w, mosi_w, miso_w, ss_w;
  int          miscompares, checked, rxn, rxs, tg, ssr, mn, iv, cyc_cnt, ndone, ldc, ld;
  logic [15:0] pw[128];
  logic [15:0] txq[$];
  logic [5:0]  bt[6] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h11, 6'h3f};

  assign sck_w  = sck_oe ? sck_o : b_sck;
  assign ss_w   = ss_oe ? ss_o : b_ss;
  assign mosi_w = mosi_oe ? mosi_o : b_mosi;
  assign miso_w = miso_oe ? miso_o : p_miso;

  spx_core DUT (.CLK(clk), .ARST_N(arst_n), .MASTER_ROLE_SELECT(mst), .CLOCK_POLARITY_SELECT(clock_polarity_select),
    .CLOCK_PHASE_SELECT(clock_phase_select), .BIT_ORDER_SELECT(lsbf), .TRANSFER_WIDTH_SELECT(w16),
    .SELECT_OUTPUT_ENABLE(soe), .FAULT_DETECT_ENABLE(fde), .BAUD_PRESELECTION_CODE(pre),
    .BAUD_RATE_SELECTION_CODE(rate), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .RX_DATA(rx_data), .RX_STROBE(rx_stb), .TRANSFER_COMPLETE_FLAG(flag), .FLAG_CLEAR(flag_clr),
    .BUSY(busy), .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE(sck_oe), .MOSI_IN(mosi_w),
    .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE(miso_oe),
    .SS_IN_N(ss_w), .SS_OUT_N(ss_o), .SS_OE(ss_oe));

  spx_peer PEER (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso), .clock_polarity_select(clock_polarity_select), .clock_phase_select(clock_phase_select),
    .lsbf(lsbf), .w16(w16), .word(pw[ndone % 128]), .got(got), .ndone(ndone));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic int hp();
    return (int'(pre) + 1) << rate;
  endfunction : hp

  function automatic logic [15:0] mk();
    return w16 ? 16'hffff : 16'h00ff;
  endfunction : mk

  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic push(input logic [15:0] w);
    tx_valid = 1'b1;
    tx_data  = w;
    do @(posedge clk); while (tx_ready !== 1'b1);
    #1;
    txq.push_back(w);
  endtask : push

  task automatic waitrx(input int k);
    int t;
    t = rxn + k;
    for (int i = 0; i < 40000 && rxn < t; i++) cyc(1);
    chk(rxn, t);
  endtask : waitrx

  // Bench acts as master on the pins in the selected phase, eight bits, most significant first.
  task automatic sx(input logic [7:0] m, output logic [7:0] r);
    int s;
    s = rxs;
    cyc(8);
    for (int i = 7; i >= 0; i--) begin
      if (clock_phase_select) b_sck = 1'b1;
      b_mosi = m[i];
      cyc(8);
      r[i]  = miso_w;
      b_sck = !clock_phase_select;
      cyc(8);
      if (!clock_phase_select) b_sck = 1'b0;
    end
    for (int i = 0; i < 200 && rxs == s; i++) cyc(1);
    chk(rxs, s + 1);
  endtask : sx

  // Model comparison at each completed master word while checking is on, monitors and the run ceiling.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 100000) begin
      miscompares++;
      final_report;
    end
    iv++;
    ldc++;
    if (sck_o !== sck_q) begin
      if (iv < mn) mn = iv;
      if (lw) ld = ldc;
      lw = 1'b0;
      iv = 0;
    end
    // Lead time: select falling to the first clock edge of that frame.
    if (ss_o === 1'b0 && ss_q === 1'b1) begin
      ldc = 0;
      lw  = 1'b1;
    end
    ss_q  = ss_o;
    sck_q = sck_o;
    if (rx_stb === 1'b1 && mst) begin
      if (chk_on) chk(rx_data, pw[rxn % 128] & mk());
      if (chk_on) chk(got, txq[rxn] & mk());
      rxn++;
    end
    if (rx_stb === 1'b1 && !mst) rxs++;
  end

  always @(sck_o) tg++;
  always @(posedge ss_o) ssr++;

  initial begin
    int         acc;
    logic       ok;
    logic [7:0] r;
    {mst, clock_polarity_select, clock_phase_select, lsbf, w16, pre, rate, tx_valid, tx_data, flag_clr, b_sck, b_mosi} = '0;
    {soe, fde, b_ss, chk_on, arst_n} = 5'h1e;
    void'($urandom(32'hd603));
    for (int i = 0; i < 128; i++) pw[i] = 16'($urandom);
    cyc(10);
    arst_n = 1'b1;
    mst    = 1'b1;
    for (int c = 0; c < 16; c++) begin
      {clock_polarity_select, clock_phase_select, lsbf, w16} = 4'(c);
      pre  = 3'($urandom % 2);
      rate = 3'(2 + $urandom % 2);
      cyc(4);
      {tg, ssr, mn, ld} = {32'd0, 32'd0, 32'd99999, 32'd0};
      push(16'($urandom));
      push(16'($urandom));
      tx_valid = 1'b0;
      waitrx(2);
      cyc(4 * hp());
      chk(tg, w16 ? 64 : 32);
      chk(ssr, clock_phase_select ? 1 : 2);
      chk(mn, hp());
      chk(ld, hp());
      chk(sck_o, clock_polarity_select);
      chk(flag, 1);
      flag_clr = 1'b1;
      cyc(1);
      flag_clr = 1'b0;
      cyc(1);
      chk(flag, 0);
    end
    // Queue words while the engine cannot send, then let them all drain.
    mst = 1'b0;
    {clock_polarity_select, clock_phase_select, lsbf, w16, pre, rate} = 10'h1c2;
    cyc(4);
    acc      = 0;
    tx_valid = 1'b1;
    do begin
      tx_data = 16'($urandom);
      @(posedge clk);
      ok = tx_ready;
      if (ok) txq.push_back(tx_data);
      if (ok) acc++;
      #1;
    end while (ok && acc < 40);
    tx_valid = 1'b0;
    chk(acc >= 32 && acc <= 34, 1);
    mst = 1'b1;
    waitrx(acc);
    chk_on = 1'b0;
    {clock_polarity_select, clock_phase_select, lsbf, w16} = 4'h0;
    for (int k = 0; k < 6; k++) begin
      {pre, rate} = bt[k];
      cyc(4);
      mn = 99999;
      ld = 0;
      push(16'h00a5);
      tx_valid = 1'b0;
      waitrx(1);
      cyc(2 * hp());
      chk(mn, hp());
      chk(ld, hp());
    end
    chk_on = 1'b1;
    mst    = 1'b0;
    cyc(4);
    chk(miso_oe, 0);
    push(16'h003c);
    tx_valid = 1'b0;
    cyc(4);
    b_ss = 1'b0;
    sx(8'h96, r);
    chk(r, 8'h3c);
    chk(rx_data, 16'h0096);
    push(16'h0071);
    tx_valid = 1'b0;
    sx(8'h4b, r);
    chk(r, 8'h96);
    b_ss = 1'b1;
    cyc(16);
    chk(miso_oe, 0);
    b_ss = 1'b0;
    sx(8'h0f, r);
    chk(r, 8'h71);
    // Phase 1 slave word after a long deselect.
    b_ss = 1'b1;
    clock_phase_select = 1'b1;
    push(16'h00c3);
    tx_valid = 1'b0;
    cyc(16);
    b_ss = 1'b0;
    sx(8'h5a, r);
    chk(r, 8'hc3);
    chk(rx_data, 16'h005a);
    final_report;
  end
endmodule : tb
`default_nettype wire

// ==== include/spx_pkg.sv ====
// Shared constants, state encoding and carrier types of the serial shift engine.
package spx_pkg;

  localparam int          SPX_DW         = 16;
  localparam int          SPX_FIFO_DEPTH = 32;
  localparam int          SPX_HALF_W     = 11;
  localparam int          SPX_CNT_W      = 12;
  localparam int          SPX_ECNT_W     = 5;
  localparam logic [4:0]  SPX_LAST_EDGE8 = 5'h0f;
  localparam logic [4:0]  SPX_LAST_EDGE16 = 5'h1f;
  localparam logic [15:0] SPX_DR_RST     = 16'h0000;
  localparam logic [11:0] SPX_CNT_MAX    = 12'hfff;
  localparam logic [11:0] SPX_PER_RST    = 12'h000;

  typedef enum logic [1:0] {
    SPX_IDLE,
    SPX_SHIFT,
    SPX_TRAIL,
    SPX_GAP
  } spx_st_e;

  typedef struct packed {
    logic       master;
    logic       clock_polarity_select;
    logic       clock_phase_select;
    logic       lsbf;
    logic       w16;
    logic       ss_out;
    logic [2:0] ppr;
    logic [2:0] spr;
  } spx_cfg_s;

  typedef struct packed {
    spx_st_e                st;
    logic [SPX_DW-1:0]      sh;
    logic                   lat;
    logic                   ob;
    logic [SPX_ECNT_W-1:0]  ecnt;
    logic [SPX_HALF_W-1:0]  div;
    logic                   sck;
    logic                   ss_n;
    logic [SPX_DW-1:0]      dr;
    logic                   dr_full;
    logic [SPX_DW-1:0]      rx;
    logic                   flag;
    logic                   rx_stb;
    logic [SPX_CNT_W-1:0]   cnt;
    logic [SPX_CNT_W-1:0]   per;
    logic [2:0]             sy1;
    logic [2:0]             sy2;
    logic                   sck_d;
    logic                   mst_d;
  } spx_state_s;

endpackage : spx_pkg

// ==== src/spx_core.sv ====
// Serial peripheral shift engine with baud divider, master and slave roles.
// Function
// R1: Polarity only sets the clock idle level.
// R2: Both ends use identical phase and polarity.
// R3: Width is 8 or 16; 2n edges.
// R4: Phase 0: first edge half period after select.
// R5: Phase 0 slave drives first bit on select.
// R6: Phase 0: latch odd edges, shift even.
// R7: Latched bit enters LSB or MSB end.
// R8: Receive word copied only after last bit.
// R9: After 2n edges words swapped, flag set.
// R10: Slave resends received word unless deselected long.
// R11: Auto select toggles between phase 0 transfers.
// R12: Phase 1: first edge after half period delay.
// R13: Phase 1: latch even, shift odd from third.
// R14: Phase 1 select may stay low throughout.
// R15: Master sends waiting word with no gap.
// R16: Flag set half period after last edge.
// R17: Zero codes divide by 2, then 4, 8.
// R18: Preselection multiplies divisor by code plus one.
// R19: Divider runs only for master during transfer.
// R20: Divisor is (pre+1) times 2^(rate+1).
// R21: Half period wait before first master clock.
// R22: Deselected slave idles, ignores clock, floats output.
`timescale 1ns/1ns
`default_nettype none
module spx_core
  import spx_pkg::*;
(
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // Configuration.
  input  wire logic              MASTER_ROLE_SELECT,
  input  wire logic              CLOCK_POLARITY_SELECT,
  input  wire logic              CLOCK_PHASE_SELECT,
  input  wire logic              BIT_ORDER_SELECT,
  input  wire logic              TRANSFER_WIDTH_SELECT,
  input  wire logic              SELECT_OUTPUT_ENABLE,
  input  wire logic              FAULT_DETECT_ENABLE,
  input  wire logic [2:0]        BAUD_PRESELECTION_CODE,
  input  wire logic [2:0]        BAUD_RATE_SELECTION_CODE,
  // Transmit words.
  input  wire logic              TX_VALID,
  output logic                   TX_READY,
  input  wire logic [SPX_DW-1:0] TX_DATA,
  // Receive words and status.
  output logic [SPX_DW-1:0]      RX_DATA,
  output logic                   RX_STROBE,
  output logic                   TRANSFER_COMPLETE_FLAG,
  input  wire logic              FLAG_CLEAR,
  output logic                   BUSY,
  // Serial pins.
  input  wire logic              SCK_IN,
  output logic                   SCK_OUT,
  output logic                   SCK_OE,
  input  wire logic              MOSI_IN,
  output logic                   MOSI_OUT,
  output logic                   MOSI_OE,
  input  wire logic              MISO_IN,
  output logic                   MISO_OUT,
  output logic                   MISO_OE,
  input  wire logic              SS_IN_N,
  output logic                   SS_OUT_N,
  output logic                   SS_OE
);

  spx_state_s            r_ff;
  spx_state_s            nxt_r;
  spx_cfg_s              cfg;
  logic [SPX_HALF_W-1:0] half;
  logic                  tick;
  logic                  last;
  logic                  s_sel;
  logic                  s_edge;
  logic                  f_valid;
  logic [SPX_DW-1:0]     f_data;

  assign cfg = '{master: MASTER_ROLE_SELECT, clock_polarity_select: CLOCK_POLARITY_SELECT, clock_phase_select: CLOCK_PHASE_SELECT,
                 lsbf: BIT_ORDER_SELECT, w16: TRANSFER_WIDTH_SELECT,
                 ss_out: SELECT_OUTPUT_ENABLE && FAULT_DETECT_ENABLE,
                 ppr: BAUD_PRESELECTION_CODE, spr: BAUD_RATE_SELECTION_CODE}; // R2

  // Half a serial period in module clocks: (pre + 1) << rate.
  assign half   = SPX_HALF_W'(({8'h00, cfg.ppr} + 11'h001) << cfg.spr); // R17 R18 R20
  assign last   = (r_ff.ecnt == (cfg.w16 ? SPX_LAST_EDGE16 : SPX_LAST_EDGE8)); // R3
  assign s_sel  = !r_ff.sy2[2];
  assign s_edge = r_ff.sy2[1] ^ r_ff.sck_d;
  assign tick   = cfg.master && (r_ff.st != SPX_IDLE) && (r_ff.div == half - 11'h001);

  spx_fifo #(
    .W (SPX_DW),
    .D (SPX_FIFO_DEPTH)
  ) u_txq (
    .CLK       (CLK),
    .ARST_N    (ARST_N),
    .IN_VALID  (TX_VALID),
    .IN_READY  (TX_READY),
    .IN_DATA   (TX_DATA),
    .OUT_VALID (f_valid),
    .OUT_READY (!r_ff.dr_full),
    .OUT_DATA  (f_data)
  );

  function automatic logic out_bit(input logic [SPX_DW-1:0] v, input spx_cfg_s c);
    out_bit = c.lsbf ? v[0] : (c.w16 ? v[15] : v[7]);
  endfunction : out_bit

  function automatic logic [SPX_DW-1:0] shift_in(input logic [SPX_DW-1:0] v, input logic b,
                                                 input spx_cfg_s c);
    if (!c.lsbf) begin
      shift_in = {v[14:0], b};
    end else if (c.w16) begin
      shift_in = {b, v[15:1]};
    end else begin
      shift_in = {v[15:8], b, v[7:1]};
    end
  endfunction : shift_in

  // One serial clock edge: odd or even numbered, by phase format.
  function automatic spx_state_s do_edge(input spx_state_s s, input logic din, input spx_cfg_s c);
    logic odd;
    odd = !s.ecnt[0];
    if (!c.clock_phase_select) begin
      if (odd) begin
        s.lat = din; // R6
      end else begin
        s.sh = shift_in(s.sh, s.lat, c); // R6 R7
        s.ob = out_bit(s.sh, c);
      end
    end else begin
      if (odd) begin
        if (s.ecnt != '0) begin
          s.sh = shift_in(s.sh, s.lat, c); // R13 R7
        end
        s.ob = out_bit(s.sh, c); // R12 R13
      end else begin
        s.lat = din; // R13
      end
    end
    return s;
  endfunction : do_edge

  // End of transfer: last shift for phase 1, copy to the receive register, flag.
  function automatic spx_state_s finish(input spx_state_s s, input spx_cfg_s c);
    if (c.clock_phase_select) begin
      s.sh = shift_in(s.sh, s.lat, c);
    end
    s.rx     = c.w16 ? s.sh : {8'h00, s.sh[7:0]}; // R8 R3
    s.rx_stb = 1'b1;
    s.flag   = 1'b1; // R9
    s.ob     = out_bit(s.sh, c);
    return s;
  endfunction : finish

  function automatic spx_state_s load(input spx_state_s s, input spx_cfg_s c);
    s.sh      = s.dr;
    s.ob      = out_bit(s.dr, c);
    s.dr_full = 1'b0;
    s.ecnt    = '0;
    s.st      = SPX_SHIFT;
    return s;
  endfunction : load

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.rx_stb = 1'b0;
    nxt_r.sy1    = {SS_IN_N, SCK_IN, cfg.master ? MISO_IN : MOSI_IN};
    nxt_r.sy2    = r_ff.sy1;
    nxt_r.sck_d  = r_ff.sy2[1];
    nxt_r.mst_d  = cfg.master;
    if (FLAG_CLEAR) begin
      nxt_r.flag = 1'b0;
    end
    if (f_valid && !r_ff.dr_full) begin
      nxt_r.dr      = f_data;
      nxt_r.dr_full = 1'b1;
    end
    nxt_r.div = (r_ff.st == SPX_IDLE || tick || !cfg.master) ? '0 : r_ff.div + 11'h001; // R19
    if (cfg.master != r_ff.mst_d) begin
      nxt_r.st   = SPX_IDLE;
      nxt_r.ss_n = 1'b1;
      nxt_r.sck  = 1'b0;
    end else if (cfg.master) begin
      case (r_ff.st)
        SPX_IDLE: begin
          nxt_r.ss_n = 1'b1;
          nxt_r.sck  = 1'b0; // R1
          if (r_ff.dr_full) begin
            nxt_r      = load(nxt_r, cfg); // R21
            nxt_r.ss_n = 1'b0; // R4 R12
          end
        end
        SPX_SHIFT: begin
          if (tick) begin
            nxt_r     = do_edge(nxt_r, r_ff.sy2[0], cfg);
            nxt_r.sck = !r_ff.sck;
            if (last) begin
              nxt_r.st = SPX_TRAIL;
            end else begin
              nxt_r.ecnt = r_ff.ecnt + 5'h01;
            end
          end
        end
        SPX_TRAIL: begin
          if (tick) begin
            nxt_r = finish(nxt_r, cfg); // R16
            if (r_ff.dr_full && (cfg.clock_phase_select || !cfg.ss_out)) begin
              nxt_r = load(nxt_r, cfg); // R15 R14
            end else if (r_ff.dr_full) begin
              nxt_r.st   = SPX_GAP;
              nxt_r.ss_n = 1'b1; // R11
            end else begin
              nxt_r.st   = SPX_IDLE;
              nxt_r.ss_n = 1'b1;
            end
          end
        end
        SPX_GAP: begin
          if (tick) begin
            nxt_r      = load(nxt_r, cfg);
            nxt_r.ss_n = 1'b0; // R11
          end
        end
        default: begin
          nxt_r.st = SPX_IDLE;
        end
      endcase
    end else begin
      nxt_r.ss_n = 1'b1;
      nxt_r.sck  = 1'b0;
      nxt_r.cnt  = (r_ff.cnt == SPX_CNT_MAX) ? r_ff.cnt : r_ff.cnt + 12'h001;
      if (!s_sel) begin
        nxt_r.st = SPX_IDLE; // R22
        if (r_ff.st != SPX_IDLE) begin
          nxt_r.cnt = '0;
        end
      end else begin
        case (r_ff.st)
          SPX_IDLE: begin
            if (r_ff.cnt >= r_ff.per) begin
              nxt_r = load(nxt_r, cfg); // R10 R5
            end else begin
              nxt_r.ob   = out_bit(r_ff.sh, cfg); // R10
              nxt_r.ecnt = '0;
              nxt_r.st   = SPX_SHIFT;
            end
          end
          SPX_SHIFT: begin
            if (s_edge) begin
              nxt_r = do_edge(nxt_r, r_ff.sy2[0], cfg);
              if (r_ff.ecnt != '0) begin
                nxt_r.per = r_ff.cnt;
              end
              nxt_r.cnt = '0;
              if (last) begin
                nxt_r.st = SPX_TRAIL;
              end else begin
                nxt_r.ecnt = r_ff.ecnt + 5'h01;
              end
            end
          end
          SPX_TRAIL: begin
            if (r_ff.cnt >= r_ff.per) begin
              nxt_r      = finish(nxt_r, cfg); // R16 R14
              nxt_r.ecnt = '0;
              nxt_r.st   = SPX_SHIFT;
            end
          end
          default: begin
            nxt_r.st = SPX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r_ff      <= '0;
      r_ff.st   <= SPX_IDLE;
      r_ff.dr   <= SPX_DR_RST;
      r_ff.ss_n <= 1'b1;
      r_ff.per  <= SPX_PER_RST;
      r_ff.sy1  <= 3'h7;
      r_ff.sy2  <= 3'h7;
      r_ff.sck_d <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign SCK_OUT                = cfg.clock_polarity_select ^ r_ff.sck; // R1
  assign SCK_OE                 = cfg.master;
  assign MOSI_OUT               = r_ff.ob;
  assign MOSI_OE                = cfg.master;
  assign MISO_OUT               = r_ff.ob;
  assign MISO_OE                = !cfg.master && s_sel; // R22
  assign SS_OUT_N               = r_ff.ss_n;
  assign SS_OE                  = cfg.master && cfg.ss_out;
  assign RX_DATA                = r_ff.rx;
  assign RX_STROBE              = r_ff.rx_stb;
  assign TRANSFER_COMPLETE_FLAG = r_ff.flag;
  assign BUSY                   = (r_ff.st != SPX_IDLE);

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_flag_set_wins: assert property (r_ff.rx_stb |-> r_ff.flag) // R9
    else $error("completion without flag");
  a_narrow_rx: assert property (r_ff.rx_stb && !cfg.w16 |-> r_ff.rx[15:8] == 8'h00) // R3
    else $error("narrow word has upper bits");
  a_divider_stopped: assert property (!cfg.master || r_ff.st == SPX_IDLE |=> r_ff.div == '0) // R19
    else $error("divider runs outside master transfer");
  a_sck_idle_level: assert property (cfg.master && r_ff.st == SPX_IDLE |-> SCK_OUT == cfg.clock_polarity_select) // R1
    else $error("clock idle level wrong");
  a_slave_float: assert property (!cfg.master && !s_sel |-> !MISO_OE ##1 r_ff.st == SPX_IDLE) // R22
    else $error("deselected slave drives output");
  a_div_by_two: assert property (cfg.ppr == 3'h0 && cfg.spr == 3'h0 |-> half == 11'h001) // R17
    else $error("zero codes not divide by two");
  a_pre_times: assert property (cfg.ppr == 3'h2 && cfg.spr == 3'h1 |-> half == 11'h006) // R18
    else $error("preselection multiply wrong");
  a_trail_flag: assert property (cfg.master && r_ff.st == SPX_TRAIL && tick && $stable(cfg.master)
                                 |=> r_ff.flag && r_ff.rx_stb) // R16
    else $error("flag not set half period after last edge");
  a_back_to_back: assert property (cfg.master && r_ff.st == SPX_TRAIL && tick && r_ff.dr_full &&
                                   cfg.clock_phase_select && $stable(cfg.master) |=> r_ff.st == SPX_SHIFT && r_ff.ecnt == 5'h00) // R15
    else $error("back to back transfer delayed");
  a_ss_gap: assert property (cfg.master && r_ff.st == SPX_TRAIL && tick && r_ff.dr_full && !cfg.clock_phase_select &&
                             cfg.ss_out && $stable(cfg.master) |=> r_ff.ss_n && r_ff.st == SPX_GAP) // R11
    else $error("select not raised between transfers");
  a_lead_delay: assert property (cfg.master && r_ff.st == SPX_IDLE && r_ff.dr_full && $stable(cfg.master)
                                 |=> !r_ff.ss_n && r_ff.sck == 1'b0 && r_ff.div == '0) // R21 R4
    else $error("first clock edge too early");

  c_master_done: cover property (cfg.master && r_ff.rx_stb);
  c_slave_done: cover property (!cfg.master && r_ff.rx_stb);
  c_back_to_back: cover property (cfg.master && r_ff.rx_stb && r_ff.st == SPX_SHIFT);

endmodule : spx_core
`default_nettype wire

// ==== src/spx_fifo.sv ====
// Transmit word FIFO with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module spx_fifo
  import spx_pkg::*;
#(
  parameter int W = SPX_DW,
  parameter int D = SPX_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic         CLK,
  input  wire logic         ARST_N,
  // Filling side.
  input  wire logic         IN_VALID,
  output logic              IN_READY,
  input  wire logic [W-1:0] IN_DATA,
  // Draining side.
  output logic              OUT_VALID,
  input  wire logic         OUT_READY,
  output logic [W-1:0]      OUT_DATA
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          ov;
    logic [W-1:0]  od;
  } spx_fifo_s;

  spx_fifo_s    r_ff;
  spx_fifo_s    nxt_r;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign IN_READY  = (r_ff.cnt != (AW+1)'(D));
  assign push      = IN_VALID && IN_READY;
  assign pop       = (r_ff.cnt != '0) && (!r_ff.ov || OUT_READY);
  assign OUT_VALID = r_ff.ov;
  assign OUT_DATA  = r_ff.od;

  always_comb begin
    nxt_r = r_ff;
    if (push) begin
      nxt_r.wp = r_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_r.rp = r_ff.rp + 1'b1;
      nxt_r.od = mem[r_ff.rp];
      nxt_r.ov = 1'b1;
    end else if (OUT_READY) begin
      nxt_r.ov = 1'b0;
    end
    nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[r_ff.wp] <= IN_DATA;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_no_overfill: assert property (r_ff.cnt <= (AW+1)'(D))
    else $error("fifo count above depth");
  c_fifo_full: cover property (!IN_READY);

endmodule : spx_fifo
`default_nettype wire
